// File: pkg/itt_consts.svh
// Constants for the interval timer tick logic
`ifndef ITT_CONSTS_SVH
`define ITT_CONSTS_SVH
`define ITT_WORD_ADDR 8'h50
`define ITT_MID_ADDR 8'h51
`define ITT_LOW_ADDR 8'h52
`define ITT_WORD_W 24
`define ITT_SIGN_BIT 23
`define ITT_CNT_W 4
`define ITT_CNT_FULL 4'hF
`define ITT_MUL_60 3'h5
`define ITT_MUL_50 3'h6
`define ITT_UNITS_PER_SEC 300
`define ITT_PH_W 2
`define ITT_PH_T2 2'h1
`define ITT_PH_T3 2'h2
`define ITT_PH_T4 2'h3
`endif

// File: pkg/itt_pkg.sv
// Types shared by the interval timer tick logic
package itt_pkg;
   typedef enum logic [1:0] {
      ITT_IDLE,
      ITT_LOAD,
      ITT_SUB,
      ITT_DONE
   } itt_upd_state_t;

   typedef struct packed {
      logic en;
      logic we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } itt_stor_req_t;

   typedef struct packed {
      logic start;
      logic [3:0] count;
      logic mul6;
   } itt_upd_req_t;
endpackage : itt_pkg

// File: rtl/itt_phase_gen.sv
// Four-phase pulse generator giving one-cycle T2, T3 and T4 enables
`timescale 1ns/1ps
`include "itt_consts.svh"
module itt_phase_gen (
   input wire logic clock,
   input wire logic arst_n,
   output logic ph_t2,
   output logic ph_t3,
   output logic phase_four_pulse
);
   import itt_pkg::*;
   typedef struct packed {
      logic [`ITT_PH_W-1:0] ph;
   } itt_ph_st_t;
   itt_ph_st_t st_r;
   itt_ph_st_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.ph = st_r.ph + `ITT_PH_W'(1);
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ph_t2 = (st_r.ph == `ITT_PH_T2);
   assign ph_t3 = (st_r.ph == `ITT_PH_T3);
   assign phase_four_pulse = (st_r.ph == `ITT_PH_T4);
endmodule : itt_phase_gen

// File: rtl/itt_tick_top.sv
// Interval timer tick counter, control latches and timer word update
// Notes on behaviour
// - Timer word: 24-bit two's complement, sign in bit 23
// - Updates remove 300 units per second
// - 60-cycle: counter advances per mains pulse
// - Four-bit counter full after 15 pulses
// - Nonzero count at phase end requests update
// - 60-cycle: subtract count times five
// - Positive to negative raises external interrupt
// - No sign change: return without interrupt
// - Counter counts only with control latch off
// - Middle byte access sets control latch unless disabled
// - Clear latch set at T4, resets counter
// - Clear latch drops control at T3, then clears
// - Drive latch set at T2, one increment
// - Full counter blocks the drive latch
// - Update request active while any bit set
// - Count transfer sets control latch again
// - Counter cleared after transfer, resumes from zero
// - 50-cycle: subtract count times six
`timescale 1ns/1ps
`include "itt_consts.svh"
module itt_tick_top (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic mains_pulse,
   input wire logic mains_50,
   input wire logic timer_disable,
   input wire logic exec_end,
   input wire itt_pkg::itt_stor_req_t stor,
   input wire logic count_xfer,
   output logic [`ITT_CNT_W-1:0] tick_count,
   output logic counter_full,
   output logic update_req,
   output logic timer_irq,
   output logic ext_irq,
   output logic upd_done,
   output logic [`ITT_WORD_W-1:0] word_value,
   output logic [7:0] rdata,
   output logic ctrl_latch_q
);
   import itt_pkg::*;

   typedef struct packed {
      logic [1:0] mains_sync;
      logic [1:0] dis_sync;
      logic [1:0] m50_sync;
      logic mains_prev;
      logic mains_pend;
      logic ctrl;
      logic clr;
      logic drive;
      logic [`ITT_CNT_W-1:0] cnt;
      logic full;
      logic upd;
      logic tirq;
      logic eirq;
      logic udone;
      logic [`ITT_WORD_W-1:0] word;
      logic [7:0] rd;
      logic start;
      logic [`ITT_CNT_W-1:0] held;
      logic mul6;
   } itt_st_t;

   itt_st_t st_r;
   itt_st_t st_nxt;
   logic ph_t2;
   logic ph_t3;
   logic phase_four_pulse;
   itt_upd_req_t upd_req;
   logic [`ITT_WORD_W-1:0] wu_word;
   logic wu_flip;
   logic wu_done;
   logic mains_edge;

   // Byte lane of the timer word; 8'h50 holds the sign
   function automatic logic [1:0] byte_sel(input logic [7:0] a);
      byte_sel = (a == `ITT_WORD_ADDR) ? 2'h2 :
                 (a == `ITT_MID_ADDR) ? 2'h1 : 2'h0;
   endfunction : byte_sel

   function automatic logic in_word(input logic [7:0] a);
      in_word = (a == `ITT_WORD_ADDR) || (a == `ITT_MID_ADDR) || (a == `ITT_LOW_ADDR);
   endfunction : in_word

   itt_phase_gen u_phase (
      .clock(clock),
      .arst_n(arst_n),
      .ph_t2(ph_t2),
      .ph_t3(ph_t3),
      .phase_four_pulse(phase_four_pulse)
   );

   assign upd_req.start = st_r.start;
   assign upd_req.count = st_r.held;
   assign upd_req.mul6 = st_r.mul6;

   itt_word_update u_upd (
      .clock(clock),
      .arst_n(arst_n),
      .req(upd_req),
      .word_in(st_r.word),
      .word_out(wu_word),
      .sign_flip(wu_flip),
      .done(wu_done)
   );

   // Only the second synchroniser stage feeds edge detection
   assign mains_edge = st_r.mains_sync[1] && !st_r.mains_prev;

   always_comb begin
      st_nxt = st_r;
      st_nxt.mains_sync = {st_r.mains_sync[0], mains_pulse};
      st_nxt.mains_prev = st_r.mains_sync[1];
      st_nxt.start = 1'b0;
      st_nxt.eirq = 1'b0;
      st_nxt.udone = 1'b0;
      // Panel switch and mains strap are pins too, so they pass two stages as well
      st_nxt.dis_sync = {st_r.dis_sync[0], timer_disable};
      st_nxt.m50_sync = {st_r.m50_sync[0], mains_50};
      st_nxt.mul6 = st_r.m50_sync[1];

      // Mains pulse held until T2 so that no pulse is missed between phases
      if (mains_edge) begin
         st_nxt.mains_pend = 1'b1;
      end

      // Drive latch: one increment per mains pulse
      st_nxt.drive = 1'b0;
      if (ph_t2 && st_r.mains_pend) begin
         st_nxt.mains_pend = mains_edge;
         if (!st_r.ctrl && !st_r.full) begin
            st_nxt.drive = 1'b1;
         end
      end
      if (st_r.drive && !st_r.ctrl && !st_r.full) begin
         st_nxt.cnt = st_r.cnt + `ITT_CNT_W'(1);
      end

      // Clear latch sequence
      if (st_r.ctrl && phase_four_pulse) begin
         st_nxt.clr = 1'b1;
      end
      if (st_r.clr) begin
         st_nxt.cnt = '0;
      end
      if (st_r.clr && ph_t3) begin
         st_nxt.ctrl = 1'b0;
      end
      if (!st_r.ctrl) begin
         st_nxt.clr = 1'b0;
      end

      // Transfer of the count to the multiplier starts a word update
      if (count_xfer) begin
         st_nxt.ctrl = 1'b1;
         st_nxt.held = st_r.cnt;
         st_nxt.start = 1'b1;
      end

      // Storage access: any read or write of the middle byte arms the counter clear, unless the disable switch is on
      if (stor.en && stor.addr == `ITT_MID_ADDR && !st_r.dis_sync[1]) begin
         st_nxt.ctrl = 1'b1;
      end
      if (stor.en && in_word(stor.addr)) begin
         case (byte_sel(stor.addr))
            2'h2: begin
               st_nxt.rd = st_r.word[23:16];
               if (stor.we) begin
                  st_nxt.word[23:16] = stor.wdata;
               end
            end
            2'h1: begin
               st_nxt.rd = st_r.word[15:8];
               if (stor.we) begin
                  st_nxt.word[15:8] = stor.wdata;
               end
            end
            default: begin
               st_nxt.rd = st_r.word[7:0];
               if (stor.we) begin
                  st_nxt.word[7:0] = stor.wdata;
               end
            end
         endcase
      end else if (stor.en) begin
         st_nxt.rd = 8'h00;
      end

      if (wu_done) begin
         st_nxt.word = wu_word;
         st_nxt.udone = 1'b1;
         st_nxt.eirq = wu_flip;
      end

      st_nxt.full = (st_nxt.cnt == `ITT_CNT_FULL);
      st_nxt.upd = (st_nxt.cnt != '0);
      // Request sampled at phase end and held until serviced
      if (exec_end && st_r.upd) begin
         st_nxt.tirq = 1'b1;
      end
      if (count_xfer) begin
         st_nxt.tirq = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick_count = st_r.cnt;
   assign counter_full = st_r.full;
   assign update_req = st_r.upd;
   assign timer_irq = st_r.tirq;
   assign ext_irq = st_r.eirq;
   assign upd_done = st_r.udone;
   assign word_value = st_r.word;
   assign rdata = st_r.rd;
   assign ctrl_latch_q = st_r.ctrl;
endmodule : itt_tick_top

// File: rtl/itt_word_update.sv
// Scales the tick count and subtracts it from the signed timer word
`timescale 1ns/1ps
`include "itt_consts.svh"
module itt_word_update (
   input wire logic clock,
   input wire logic arst_n,
   input wire itt_pkg::itt_upd_req_t req,
   input wire logic [`ITT_WORD_W-1:0] word_in,
   output logic [`ITT_WORD_W-1:0] word_out,
   output logic sign_flip,
   output logic done
);
   import itt_pkg::*;
   typedef struct packed {
      logic [`ITT_WORD_W-1:0] word;
      logic flip;
      logic done;
   } itt_wu_st_t;
   itt_wu_st_t st_r;
   itt_wu_st_t st_nxt;
   logic [6:0] amount;
   logic [`ITT_WORD_W-1:0] diff;

   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      st_nxt.flip = 1'b0;
      amount = req.count * (req.mul6 ? `ITT_MUL_50 : `ITT_MUL_60);
      diff = word_in - {17'h00000, amount};
      if (req.start) begin
         st_nxt.word = diff;
         st_nxt.done = 1'b1;
         // Positive to negative only; an already negative word stays quiet
         st_nxt.flip = !word_in[`ITT_SIGN_BIT] && diff[`ITT_SIGN_BIT];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign word_out = st_r.word;
   assign sign_flip = st_r.flip;
   assign done = st_r.done;
endmodule : itt_word_update

// File: tb/itt_micro_model.sv
// Microprogram model that moves the tick count out on a timer interrupt
`timescale 1ns/1ps
module itt_micro_model (
   input wire logic clock,
   input wire logic timer_irq,
   input wire logic slow,
   output logic count_xfer
);
   initial begin
      count_xfer = 1'b0;
      forever begin
         @(posedge clock);
         // Look once the edge has settled, never in the step that launches the flag
         #10;
         if (timer_irq === 1'b1) begin
            // Slow answer stands for a long instruction still running
            repeat (slow ? 7 : 1) @(posedge clock);
            #10 count_xfer = 1'b1;
            @(posedge clock);
            #10 count_xfer = 1'b0;
            repeat (2) @(posedge clock);
         end
      end
   end
endmodule : itt_micro_model

// File: tb/itt_tick_chk.sv
// Checker for the interval timer tick logic
`timescale 1ns/1ps
`include "itt_consts.svh"
module itt_tick_chk (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic timer_disable,
   input wire logic exec_end,
   input wire itt_pkg::itt_stor_req_t stor,
   input wire logic count_xfer,
   input wire logic [`ITT_CNT_W-1:0] tick_count,
   input wire logic counter_full,
   input wire logic update_req,
   input wire logic timer_irq,
   input wire logic ext_irq,
   input wire logic upd_done,
   input wire logic [`ITT_WORD_W-1:0] word_value,
   input wire logic ctrl_latch_q
);
   import itt_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // The switch reaches the arming logic through a two-stage synchroniser
   sequence s_arm;
      stor.en && stor.addr == `ITT_MID_ADDR && !$past(timer_disable, 2);
   endsequence
   sequence s_clear;
      ##[1:6] tick_count == 4'h0 ##[1:5] !ctrl_latch_q;
   endsequence
   a_full_flag: assert property (counter_full == (tick_count == `ITT_CNT_FULL))
      else $error("full flag wrong");
   a_req_any: assert property (update_req == (tick_count != 4'h0))
      else $error("update request wrong");
   a_word_arm: assert property (s_arm |=> ctrl_latch_q)
      else $error("control latch not set");
   a_dis_arm: assert property (stor.en && stor.addr == `ITT_MID_ADDR
      && $past(timer_disable, 2) && !ctrl_latch_q && !count_xfer |=> !ctrl_latch_q)
      else $error("disabled access armed");
   a_xfer_arm: assert property (count_xfer |=> ctrl_latch_q && !timer_irq)
      else $error("transfer did not arm");
   a_clear_seq: assert property ($rose(ctrl_latch_q) |-> s_clear)
      else $error("clear sequence wrong");
   a_hold_ctrl: assert property (ctrl_latch_q && $past(ctrl_latch_q)
      && $past(ctrl_latch_q, 2)
      |-> !(tick_count != 4'h0 && tick_count == $past(tick_count) + 4'h1))
      else $error("counted while held");
   a_one_step: assert property (tick_count != $past(tick_count)
      |-> tick_count == $past(tick_count) + 4'h1 || tick_count == 4'h0)
      else $error("count jumped");
   a_full_stop: assert property (counter_full && !ctrl_latch_q
      && !count_xfer && !stor.en |=> counter_full)
      else $error("full counter moved");
   a_timer_req: assert property (exec_end && update_req && !count_xfer |=> timer_irq)
      else $error("timer interrupt missing");
   a_upd_time: assert property (count_xfer |-> ##3 upd_done)
      else $error("update late");
   a_ext_flip: assert property (ext_irq
      |-> upd_done && word_value[23] && !$past(word_value[23]))
      else $error("spurious external interrupt");
   a_no_flip: assert property (upd_done && word_value[23] == $past(word_value[23])
      |-> !ext_irq)
      else $error("interrupt without sign change");
endmodule : itt_tick_chk
bind itt_tick_top itt_tick_chk u_chk (.clock, .arst_n, .timer_disable, .exec_end, .stor,
   .count_xfer, .tick_count, .counter_full, .update_req, .timer_irq, .ext_irq, .upd_done,
   .word_value, .ctrl_latch_q);

// File: tb/itt_tick_top_bench.sv
// Self-checking bench for the interval timer tick logic
`timescale 1ns/1ps
`include "itt_consts.svh"
module itt_tick_top_bench;
   import itt_pkg::*;
   logic clock = 1'b0, arst_n = 1'b0, mains_pulse = 1'b0, mains_50 = 1'b0;
   logic timer_disable = 1'b0, exec_end = 1'b0, slow = 1'b0, rd_q = 1'b0, count_xfer;
   logic counter_full, update_req, timer_irq, ext_irq, upd_done, ctrl_latch_q;
   itt_stor_req_t stor = '0;
   logic [3:0] tick_count;
   logic [23:0] word_value, word_m = '0;
   logic [7:0] rdata;
   logic [24:0] wq[$];
   logic [7:0] rq[$];
   logic [31:0] seed = 32'h35;
   int fail_count = 0, check_count = 0;
   always #50 clock = ~clock;
   itt_tick_top DUT (.clock, .arst_n, .mains_pulse, .mains_50, .timer_disable, .exec_end,
      .stor, .count_xfer, .tick_count, .counter_full, .update_req, .timer_irq, .ext_irq,
      .upd_done, .word_value, .rdata, .ctrl_latch_q);
   itt_micro_model u_micro (.clock, .timer_irq, .slow, .count_xfer);
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #10;
   endtask : tick
   task automatic chk(input logic [24:0] g, input logic [24:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] d);
      stor = '{1'b1, we, a, d};
      if (!we) rq.push_back((a >= 8'h50 && a <= 8'h52) ? 8'(word_m >> ((8'h52 - a) * 8)) : 8'h00);
      tick(1);
      stor.en = 1'b0;
      tick(1);
   endtask : acc
   task automatic wr_word(input logic [23:0] w);
      acc(1'b1, 8'h50, w[23:16]);
      acc(1'b1, 8'h51, w[15:8]);
      acc(1'b1, 8'h52, w[7:0]);
      word_m = w;
   endtask : wr_word
   task automatic pulses(input int n);
      tick(10);
      repeat (n) begin
         mains_pulse = 1'b1;
         tick(3);
         mains_pulse = 1'b0;
         tick(5);
      end
      tick(6);
   endtask : pulses
   task automatic service(input int n, input logic [2:0] m);
      logic [23:0] nw;
      nw = word_m - 24'(n * m);
      wq.push_back({~word_m[23] & nw[23], nw});
      word_m = nw;
      exec_end = 1'b1;
      tick(1);
      exec_end = 1'b0;
      chk(timer_irq, 1'b1);
      tick(20);
   endtask : service
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict
   always @(negedge clock) begin
      if (rd_q) chk(rdata, rq.pop_front());
      if (upd_done === 1'b1) chk({ext_irq, word_value}, wq.pop_front());
      rd_q <= stor.en & ~stor.we;
   end
   initial begin : watchdog
      #2000000;
      fail_count++;
      give_verdict();
   end
   initial begin : main
      repeat (10) @(posedge clock);
      #10 arst_n = 1'b1;
      tick(1);
      chk({ctrl_latch_q, word_value}, 25'h0);
      seed = xs(seed);
      wr_word({16'h0000, 8'h08 | (seed[7:0] & 8'h07)});
      tick(10);
      chk(ctrl_latch_q, 1'b0);
      for (int a = 8'h50; a < 8'h54; a++) acc(1'b0, 8'(a), 8'h00);
      $display("test 1 done");
      pulses(3);
      chk(tick_count, 25'h3);
      chk({timer_irq, update_req}, 25'h1);
      service(3, `ITT_MUL_60);
      chk(tick_count, 25'h0);
      $display("test 2 done");
      mains_50 = 1'b1;
      slow = 1'b1;
      seed = xs(seed);
      wr_word({8'h7F, seed[15:0]});
      pulses(17);
      chk({counter_full, tick_count}, 25'h1F);
      service(15, `ITT_MUL_50);
      $display("test 3 done");
      timer_disable = 1'b1;
      pulses(2);
      wr_word(seed[31:8]);
      chk({ctrl_latch_q, tick_count}, 25'h2);
      $display("test 4 done");
      // Results still waiting in a queue mean an answer never came
      chk(25'(wq.size() + rq.size()), 25'h0);
      give_verdict();
   end
endmodule : itt_tick_top_bench
